/* File: mii_defines.svh */
`ifndef MII_DEFINES_SVH
`define MII_DEFINES_SVH
`define MII_SEL_MII 3'h0
`define MII_FIFO_W 6
`define MII_FIFO_D 8
`define MII_PRE_NIB 4'h5
`define MII_SFD_NIB 4'hD
`define MII_PRE_FIRST 4'h1
`define MII_PRE_LAST 4'hF
`define MII_CRC_INIT 32'hFFFFFFFF
`define MII_CRC_POLY 32'hEDB88320
`define MII_CRC_LAST 4'h7
`define MII_IFG_NIBS 5'h18
`define MII_MD_ONES 32'hFFFFFFFF
`define MII_MD_ST 2'h1
`define MII_MD_OP_RD 2'h2
`define MII_MD_OP_WR 2'h1
`define MII_MD_TA 2'h2
`define MII_MD_BITS 7'h40
`define MII_MD_DATA_IDX 7'h30
`endif

/* File: mii_fifo.sv */
`timescale 1ns/10ps
`include "mii_defines.svh"
module mii_fifo #(
   parameter int WIDTH = `MII_FIFO_W,
   parameter int DEPTH = `MII_FIFO_D
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   mii_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } mii_fifo_st_t;
   mii_fifo_st_t r, next_r;
   logic push, pop;

   assign f.wrReady = r.cnt != (AW+1)'(DEPTH);
   assign f.rdValid = r.cnt != '0;
   assign f.rdData = r.mem[r.rp];
   assign push = f.wrValid & f.wrReady;
   assign pop = f.rdValid & f.rdReady;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.mem[r.wp] = f.wrData;
         next_r.wp = AW'(r.wp + 1'b1);
      end
      if (pop) begin
         next_r.rp = AW'(r.rp + 1'b1);
      end
      if (push && !pop) begin
         next_r.cnt = (AW+1)'(r.cnt + 1'b1);
      end else if (pop && !push) begin
         next_r.cnt = (AW+1)'(r.cnt - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end
endmodule: mii_fifo

/* File: mii_fifo_if.sv */
`timescale 1ns/10ps
`include "mii_defines.svh"
interface mii_fifo_if #(parameter int W = `MII_FIFO_W);
   logic [W-1:0] wrData;
   logic wrValid;
   logic wrReady;
   logic [W-1:0] rdData;
   logic rdValid;
   logic rdReady;
   modport fifo(input wrData, wrValid, rdReady,
      output wrReady, rdData, rdValid);
   modport user(output wrData, wrValid, rdReady,
      input wrReady, rdData, rdValid);
endinterface: mii_fifo_if

/* File: mii_mac_if.sv */
// Contract
// - MII path serves 10 and 100 Mbps only; no gigabit mode here.
// - A transmit error is signalled by sending the frame check inverted.
// - Transmit nibble, bit zero least significant, valid only with enable.
// - Transmit enable follows the transmit clock while frame data is sent.
// - Collision is asynchronous and used only in half duplex.
// - Carrier sense is asynchronous and used only in half duplex.
// - Receive nibble sampled on receive clock, accepted only while valid.
// - Receive error counts only while valid and marks the frame errored.
// - Management clock is sourced here, rate set by the divider field.
// - Data pin driven in every frame cycle except read data cycles.
// - Switch link forces full duplex; carrier and collision are ignored.
// - MII exists only on first MAC; second MAC then has RGMII only.
// - MII is selected when the first MAC select input is zero.
`timescale 1ns/10ps
`include "mii_defines.svh"
module mii_mac_if
   import mii_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [2:0] firstMacIfSelect,
   input wire logic fullDuplex,
   input wire logic switchMode,
   output logic miiActive,
   output logic secondMacRgmiiOnly,
   input wire logic phyTxClock,
   output logic [3:0] txNibble,
   output logic txEnableOut,
   input wire logic collisionIn,
   input wire logic carrierSenseIn,
   input wire logic phyRxClock,
   input wire logic [3:0] rxNibble,
   input wire logic rxValidIn,
   input wire logic rxErrorIn,
   input wire logic [3:0] txData,
   input wire logic txLast,
   input wire logic txAbort,
   input wire logic txValid,
   output logic txReady,
   output logic txDone,
   output logic txCollision,
   output logic [3:0] rxData,
   output logic rxStrobe,
   output logic rxEnd,
   output logic rxFrameErr,
   input wire logic [7:0] mgmtClockDivider,
   input wire logic mgmtStart,
   input wire logic mgmtRead,
   input wire logic [4:0] mgmtPhyAddr,
   input wire logic [4:0] mgmtRegAddr,
   input wire logic [15:0] mgmtWrData,
   output logic mgmtBusy,
   output logic mgmtDone,
   output logic [15:0] mgmtRdData,
   output logic mgmtClockOut,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   mii_state_t r, next_r;
   mii_txw_t w;
   logic txEdge, rxEdge, halfDup, canStart, pop;
   logic mdTick, mdRise, mdFall, txGo, rxGo;

   mii_fifo_if #(.W($bits(mii_txw_t))) f();

   mii_fifo #(.WIDTH($bits(mii_txw_t)), .DEPTH(`MII_FIFO_D)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .f(f)
   );

   function automatic logic [31:0] crc_nib(input logic [31:0] c,
      input logic [3:0] d);
      logic [31:0] x;
      x = c;
      for (int i = 0; i < 4; i++) begin
         if (x[0] ^ d[i]) begin
            x = (x >> 1) ^ `MII_CRC_POLY;
         end else begin
            x = x >> 1;
         end
      end
      return x;
   endfunction: crc_nib

   // ****************************************************************
   // Mode and pin sharing
   // ****************************************************************
   // No gigabit path exists; speed follows the PHY clocks alone
   assign miiActive = firstMacIfSelect == `MII_SEL_MII;
   assign secondMacRgmiiOnly = miiActive;
   assign halfDup = ~fullDuplex & ~switchMode;

   // ****************************************************************
   // Edge events and FIFO hookup
   // ****************************************************************
   assign txEdge = r.tclkS2 & ~r.tclkPrev;
   // Receive side samples mid-period, where the PHY data is settled
   assign rxEdge = r.rclkPrev & ~r.rclkS2;
   assign txGo = ce & txEdge;
   assign rxGo = ce & rxEdge;
   assign mdTick = r.divCnt == mgmtClockDivider;
   assign mdRise = mdTick & ~r.mdc;
   assign mdFall = mdTick & r.mdc;
   assign w = mii_txw_t'(f.rdData);
   assign canStart = miiActive & f.rdValid & ~(halfDup & r.crsS2);
   assign pop = txEdge & (r.txSt == TX_DATA);
   assign f.wrData = {txAbort, txLast, txData};
   assign f.wrValid = txValid;
   assign f.rdReady = pop;
   assign txReady = f.wrReady;

   assign txNibble = r.txNib;
   assign txEnableOut = r.txEn;
   assign txDone = r.txDone;
   assign txCollision = r.txColl;
   assign rxData = r.rxNib;
   assign rxStrobe = r.rxStb;
   assign rxEnd = r.rxEnd;
   assign rxFrameErr = r.rxBad;
   assign mgmtBusy = r.mdBusy;
   assign mgmtDone = r.mdDone;
   assign mgmtRdData = r.mdRd;
   assign mgmtClockOut = r.mdc;
   assign mdioOut = r.mdOut;
   assign mdioOe = r.mdOe;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_r = r;
      next_r.txDone = 1'b0;
      next_r.txColl = 1'b0;
      next_r.rxStb = 1'b0;
      next_r.rxEnd = 1'b0;
      next_r.mdDone = 1'b0;
      // Pins from other clocks pass two flops first
      next_r.tclkS1 = phyTxClock;
      next_r.tclkS2 = r.tclkS1;
      next_r.tclkPrev = r.tclkS2;
      next_r.crsS1 = carrierSenseIn;
      next_r.crsS2 = r.crsS1;
      next_r.colS1 = collisionIn;
      next_r.colS2 = r.colS1;
      next_r.rclkS1 = phyRxClock;
      next_r.rclkS2 = r.rclkS1;
      next_r.rclkPrev = r.rclkS2;
      next_r.dvS1 = rxValidIn;
      next_r.dvS2 = r.dvS1;
      next_r.erS1 = rxErrorIn;
      next_r.erS2 = r.erS1;
      next_r.rnS1 = rxNibble;
      next_r.rnS2 = r.rnS1;
      next_r.mdS1 = mdioIn;
      next_r.mdS2 = r.mdS1;

      // Transmit engine, one step per transmit clock rise
      if (txEdge) begin
         case (r.txSt)
            TX_IDLE: begin
               next_r.txEn = 1'b0;
               if (r.ifg != '0) begin
                  next_r.ifg = 5'(r.ifg - 1'b1);
               end else if (canStart) begin
                  next_r.txSt = TX_PRE;
                  next_r.txEn = 1'b1;
                  next_r.txNib = `MII_PRE_NIB;
                  next_r.cnt = `MII_PRE_FIRST;
                  next_r.crc = `MII_CRC_INIT;
                  next_r.bad = 1'b0;
               end
            end
            TX_PRE: begin
               if (r.cnt == `MII_PRE_LAST) begin
                  next_r.txNib = `MII_SFD_NIB;
                  next_r.txSt = TX_DATA;
               end else begin
                  next_r.txNib = `MII_PRE_NIB;
                  next_r.cnt = 4'(r.cnt + 1'b1);
               end
            end
            TX_DATA: begin
               next_r.cnt = '0;
               if (f.rdValid) begin
                  next_r.txNib = w.nib;
                  next_r.crc = crc_nib(r.crc, w.nib);
                  next_r.bad = r.bad | w.err;
                  if (w.last) begin
                     next_r.txSt = TX_FCS;
                  end
               end else begin
                  // Underrun cannot be recovered; poison the frame
                  next_r.bad = 1'b1;
                  next_r.txSt = TX_FCS;
               end
            end
            TX_FCS: begin
               next_r.txNib = r.bad ? r.crc[3:0] : ~r.crc[3:0];
               next_r.crc = r.crc >> 4;
               next_r.cnt = 4'(r.cnt + 1'b1);
               if (r.cnt == `MII_CRC_LAST) begin
                  next_r.txSt = TX_IDLE;
                  next_r.txDone = 1'b1;
                  next_r.ifg = `MII_IFG_NIBS;
               end
            end
            default: begin
               next_r.txSt = TX_IDLE;
            end
         endcase
         // A collision spoils the frame but never cuts it short
         if (halfDup && r.colS2 && r.txEn && r.txSt != TX_IDLE) begin
            next_r.bad = 1'b1;
            next_r.txColl = 1'b1;
         end
      end

      // Receive path
      if (rxEdge) begin
         if (miiActive && r.dvS2) begin
            next_r.rxNib = r.rnS2;
            next_r.rxStb = 1'b1;
            next_r.inFrame = 1'b1;
            next_r.errAcc = r.errAcc | r.erS2;
         end else if (r.inFrame) begin
            next_r.rxEnd = 1'b1;
            next_r.rxBad = r.errAcc;
            next_r.inFrame = 1'b0;
            next_r.errAcc = 1'b0;
         end
      end

      // Management clock divider, runs free
      if (mdTick) begin
         next_r.divCnt = '0;
         next_r.mdc = ~r.mdc;
      end else begin
         next_r.divCnt = 8'(r.divCnt + 1'b1);
      end

      // Management frame: bits change on falling clock, read on rising
      if (!r.mdBusy && mgmtStart) begin
         next_r.mdBusy = 1'b1;
         next_r.mdRead = mgmtRead;
         next_r.mdCnt = '0;
         next_r.mdRd = '0;
         next_r.mdSh = {`MII_MD_ONES, `MII_MD_ST,
            mgmtRead ? `MII_MD_OP_RD : `MII_MD_OP_WR,
            mgmtPhyAddr, mgmtRegAddr, `MII_MD_TA,
            mgmtRead ? 16'h0000 : mgmtWrData};
      end else if (r.mdBusy && mdFall) begin
         if (r.mdCnt == `MII_MD_BITS) begin
            next_r.mdBusy = 1'b0;
            next_r.mdDone = 1'b1;
            next_r.mdOe = 1'b0;
         end else begin
            next_r.mdOut = r.mdSh[63];
            next_r.mdSh = {r.mdSh[62:0], 1'b0};
            next_r.mdCnt = 7'(r.mdCnt + 1'b1);
            // Release the pin only for the data bits of a read
            next_r.mdOe = !(r.mdRead && r.mdCnt >= `MII_MD_DATA_IDX);
         end
      end else if (r.mdBusy && mdRise && r.mdRead &&
         r.mdCnt > `MII_MD_DATA_IDX) begin
         next_r.mdRd = {r.mdRd[14:0], r.mdS2};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence txStartSeq;
      txGo && r.txSt == TX_IDLE && r.ifg == '0 && canStart;
   endsequence
   sequence preambleSeq;
      r.txSt == TX_PRE && txEnableOut && txNibble == `MII_PRE_NIB;
   endsequence
   sequence rxBadSeq;
      rxGo && miiActive && r.dvS2 && r.erS2;
   endsequence

   pre_start_a: assert property (txStartSeq |=> preambleSeq)
      else $error("frame start did not open with preamble");
   fcs_inv_a: assert property ((txGo && r.txSt == TX_FCS) |=>
      txNibble == ($past(r.bad) ? $past(r.crc[3:0]) : ~$past(r.crc[3:0])))
      else $error("frame check nibble has wrong polarity");
   tx_sync_a: assert property ((!txEdge) |=>
      ($stable(txNibble) && $stable(txEnableOut)))
      else $error("transmit pins moved without a transmit clock rise");
   defer_crs_a: assert property ((txGo && r.txSt == TX_IDLE &&
      halfDup && r.crsS2) |=> r.txSt == TX_IDLE)
      else $error("transmit began while carrier was sensed");
   coll_bad_a: assert property ((txGo && halfDup && r.colS2 &&
      r.txSt == TX_DATA) |=> (r.bad && txCollision))
      else $error("collision did not spoil the frame");
   full_dup_a: assert property ((txGo && switchMode &&
      r.txSt == TX_IDLE && r.ifg == '0 && miiActive && f.rdValid)
      |=> r.txSt == TX_PRE)
      else $error("switch link deferred on carrier or collision");
   sel_gate_a: assert property ((txGo && r.txSt == TX_IDLE &&
      !miiActive) |=> (r.txSt == TX_IDLE && !txEnableOut))
      else $error("transmit started with MII not selected");
   rx_valid_a: assert property ($rose(rxStrobe) |->
      (rxData == $past(r.rnS2) && $past(r.dvS2)))
      else $error("receive nibble accepted without valid");
   rx_err_a: assert property (rxBadSeq |=> r.errAcc)
      else $error("receive error was not recorded");
   rx_end_a: assert property ($rose(rxEnd) |->
      rxFrameErr == $past(r.errAcc))
      else $error("frame end lost the error mark");
   mdc_div_a: assert property ($changed(mgmtClockOut) |->
      (r.divCnt == '0 && $past(r.divCnt) == $past(mgmtClockDivider)))
      else $error("management clock ignored the divider");
   md_read_a: assert property ((r.mdBusy && r.mdRead &&
      r.mdCnt > `MII_MD_DATA_IDX) |-> !mdioOe)
      else $error("data pin driven during read data bits");
   md_write_a: assert property ((r.mdBusy && !r.mdRead &&
      r.mdCnt != '0) |-> mdioOe)
      else $error("data pin released during a write frame");
   sync2_a: assert property (ce |=>
      (!ce || r.colS2 == $past(r.colS1)))
      else $error("collision bypassed its second flop");
endmodule: mii_mac_if

/* File: mii_mac_if_tb.sv */
`timescale 1ns/10ps
`include "mii_defines.svh"
module mii_mac_if_tb;
   // *****
   // Signals and instances
   // *****
   logic clk, rstn = 1'b0, fullDuplex = 1'b1, switchMode = 1'b0;
   logic txLast = 1'b0, txAbort = 1'b0, txValid = 1'b0, mgmtStart = 1'b0;
   logic collisionIn = 1'b0, carrierSenseIn = 1'b0, mgmtRead = 1'b0;
   logic [2:0] firstMacIfSelect = 3'h0;
   logic [3:0] txData = 4'h0, rxNibble, txNibble, rxData;
   logic [4:0] mgmtPhyAddr = 5'h00, mgmtRegAddr = 5'h00;
   logic [7:0] mgmtClockDivider = 8'h07;
   logic [15:0] mgmtWrData = 16'h0000, mgmtRdData;
   logic miiActive, secondMacRgmiiOnly, phyTxClock, phyRxClock;
   logic txEnableOut, rxValidIn, rxErrorIn, txReady, txDone, txCollision;
   logic rxStrobe, rxEnd, rxFrameErr, mgmtBusy, mgmtDone, mgmtClockOut;
   logic mdioOut, mdioOe, phyMdio;
   logic ce = 1'b1, mdcSeen;
   wire mdioIn = (mdioOe === 1'b1) ? mdioOut : phyMdio;
   int errors = 0, n_checks = 0, cyc = 0, nColl = 0;
   int nb[5] = '{8, 1, 8, 5, 3};
   logic [5:0] cfgs[5] = '{6'h02, 6'h03, 6'h18, 6'h1C, 6'h22};
   logic [7:0] divs[2] = '{8'h02, 8'h07};
   logic [31:0] lfsr = 32'h4CF2;
   logic [3:0] rxGot[$];
   time t0;
   mii_mac_if dut (.*);
   mii_phy_model model (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (txCollision === 1'b1) nColl++;
      if (rxStrobe === 1'b1) rxGot.push_back(rxData);
      if (cyc == 50000) begin
         errors++;
         final_report();
      end
   end
   // *****
   // Helpers
   // *****
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask: check
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask: final_report
   function automatic logic [31:0] nextRand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction: nextRand
   // Reflected CRC, one nibble at a time, low bit first
   function automatic logic [31:0] crcNib(logic [31:0] c, logic [3:0] n);
      c = c ^ {28'h0, n};
      for (int i = 0; i < 4; i++) c = c[0] ? (c >> 1) ^ `MII_CRC_POLY : c >> 1;
      return c;
   endfunction: crcNib
   task automatic push(logic [3:0] d, logic last, logic ab);
      txValid <= 1'b1;
      txData <= d;
      txLast <= last;
      txAbort <= ab;
      do @(posedge clk); while (txReady !== 1'b1);
   endtask: push
   // *****
   // Scenarios
   // *****
   // cfg bits: 0 abort, 1 full duplex, 2 switch, 3 collision, 4 carrier,
   // 5 other interface selected first
   task automatic frame(int n, logic [5:0] cfg);
      logic [31:0] c;
      logic [3:0] q[$];
      logic half;
      half = !cfg[1] && !cfg[2];
      fullDuplex <= cfg[1];
      switchMode <= cfg[2];
      carrierSenseIn <= cfg[4];
      firstMacIfSelect <= cfg[5] ? 3'h3 : 3'h0;
      model.txCap.delete();
      nColl = 0;
      c = `MII_CRC_INIT;
      for (int i = 0; i < 15; i++) q.push_back(`MII_PRE_NIB);
      q.push_back(`MII_SFD_NIB);
      for (int i = 0; i < n; i++) begin
         lfsr = nextRand(lfsr);
         q.push_back(lfsr[3:0]);
         c = crcNib(c, lfsr[3:0]);
         push(lfsr[3:0], i == n - 1, cfg[0] && i == n - 1);
      end
      txValid <= 1'b0;
      @(posedge clk);
      if (n == 8) check("txReady full", txReady, 1'b0);
      if (cfg[5] || (cfg[4] && half)) begin
         repeat (1500) @(posedge clk);
         check("held back", txEnableOut, 1'b0);
         check("miiActive", miiActive, !cfg[5]);
         check("rgmiiOnly", secondMacRgmiiOnly, !cfg[5]);
         carrierSenseIn <= 1'b0;
         firstMacIfSelect <= 3'h0;
      end
      for (int t = 0; t < 2000 && txEnableOut !== 1'b1; t++) @(posedge clk);
      check("started", txEnableOut, 1'b1);
      if (cfg[3]) begin
         // Land the collision inside the frame body, past the preamble
         repeat (700) @(posedge clk);
         collisionIn <= 1'b1;
         repeat (100) @(posedge clk);
         collisionIn <= 1'b0;
      end
      for (int t = 0; t < 3000 && txDone !== 1'b1; t++) @(posedge clk);
      check("txDone", txDone, 1'b1);
      c = (cfg[0] || (cfg[3] && half)) ? c : ~c;
      for (int i = 0; i < 8; i++) q.push_back(c[4*i +: 4]);
      for (int t = 0; t < 100 && txEnableOut !== 1'b0; t++) @(posedge clk);
      check("tx length", model.txCap.size(), q.size());
      foreach (q[i]) check("tx nibble", model.txCap[i], q[i]);
      check("collision", nColl != 0, cfg[3] && half);
   endtask: frame
   task automatic rxFrame(int n, logic err);
      logic [3:0] q[$];
      rxGot.delete();
      model.rxSend.push_back({2'b01, 4'hA});
      for (int i = 0; i < n; i++) begin
         lfsr = nextRand(lfsr);
         q.push_back(lfsr[7:4]);
         model.rxSend.push_back({1'b1, err && i == 1, lfsr[7:4]});
      end
      for (int t = 0; t < 3000 && rxEnd !== 1'b1; t++) @(posedge clk);
      @(posedge clk);
      check("rx error", rxFrameErr, err);
      check("rx length", rxGot.size(), n);
      foreach (q[i]) check("rx nibble", rxGot[i], q[i]);
   endtask: rxFrame
   task automatic mgmt(logic rd);
      logic [63:0] exp;
      @(posedge clk);
      lfsr = nextRand(lfsr);
      exp = {`MII_MD_ONES, `MII_MD_ST, rd ? `MII_MD_OP_RD : `MII_MD_OP_WR,
         lfsr[4:0], lfsr[9:5], `MII_MD_TA, lfsr[31:16]};
      model.rdVal = lfsr[25:10];
      model.mdCnt = 0;
      mgmtRead <= rd;
      mgmtPhyAddr <= lfsr[4:0];
      mgmtRegAddr <= lfsr[9:5];
      mgmtWrData <= lfsr[31:16];
      mgmtStart <= 1'b1;
      @(posedge clk);
      mgmtStart <= 1'b0;
      @(posedge clk);
      check("mgmtBusy", mgmtBusy, 1'b1);
      for (int t = 0; t < 3000 && mgmtDone !== 1'b1; t++) @(posedge clk);
      check("md driven bits", model.mdCnt, rd ? 48 : 64);
      check("md frame",
         rd ? {16'h0, model.mdCap[47:0]} : model.mdCap, rd ? exp >> 16 : exp);
      if (rd) check("md read", mgmtRdData, lfsr[25:10]);
   endtask: mgmt
   initial begin
      repeat (3) @(posedge clk);
      check("txReady reset", txReady, 1'b1);
      check("miiActive", miiActive, 1'b1);
      check("rgmiiOnly", secondMacRgmiiOnly, 1'b1);
      check("txEnable reset", txEnableOut, 1'b0);
      rstn <= 1'b1;
      foreach (nb[k]) frame(nb[k], cfgs[k]);
      rxFrame(6, 1'b0);
      rxFrame(4, 1'b1);
      foreach (divs[k]) begin
         mgmtClockDivider <= divs[k];
         repeat (3) @(posedge mgmtClockOut);
         t0 = $time;
         @(posedge mgmtClockOut);
         check("md period", $time - t0, 20 * (divs[k] + 1));
      end
      mgmt(1'b0);
      mgmt(1'b1);
      // Clock enable low must freeze even the free running divider
      ce <= 1'b0;
      @(posedge clk);
      mdcSeen = mgmtClockOut;
      repeat (40) @(posedge clk);
      check("ce freeze", mgmtClockOut, mdcSeen);
      ce <= 1'b1;
      @(posedge clk);
      final_report();
   end
endmodule: mii_mac_if_tb

/* File: mii_phy_model.sv */
`timescale 1ns/10ps
module mii_phy_model (
   output logic phyTxClock,
   output logic phyRxClock,
   output logic [3:0] rxNibble,
   output logic rxValidIn,
   output logic rxErrorIn,
   output logic phyMdio,
   input wire logic [3:0] txNibble,
   input wire logic txEnableOut,
   input wire logic mgmtClockOut,
   input wire logic mdioOut,
   input wire logic mdioOe
);
   // *****
   // Clocks and line capture
   // *****
   logic [3:0] txCap[$];
   logic [5:0] rxSend[$];
   logic [63:0] mdCap;
   logic [15:0] rdVal = 16'hFFFF;
   int mdCnt = 0;
   int rdIdx = 0;
   // Free running, phase unrelated to the system clock
   initial begin
      phyTxClock = 1'b0;
      forever #200 phyTxClock = ~phyTxClock;
   end
   initial begin
      phyRxClock = 1'b0;
      #73;
      forever #200 phyRxClock = ~phyRxClock;
   end
   initial begin
      rxNibble = 4'h0;
      rxValidIn = 1'b0;
      rxErrorIn = 1'b0;
      phyMdio = 1'b1;
   end
   always @(negedge phyTxClock) begin
      if (txEnableOut === 1'b1) txCap.push_back(txNibble);
   end
   // Idle nibbles toggle so stale data never passes for a frame
   always @(posedge phyRxClock) begin
      if (rxSend.size() > 0) begin
         {rxValidIn, rxErrorIn, rxNibble} <= rxSend.pop_front();
      end else begin
         rxValidIn <= 1'b0;
         rxErrorIn <= 1'b0;
         rxNibble <= ~rxNibble;
      end
   end
   // *****
   // Management pin
   // *****
   always @(posedge mgmtClockOut) begin
      if (mdioOe === 1'b1) begin
         mdCap <= {mdCap[62:0], mdioOut};
         mdCnt <= mdCnt + 1;
      end
   end
   // Drive well clear of the sampling rise; pull-up level otherwise
   always @(negedge mgmtClockOut) begin
      #25;
      if (mdioOe !== 1'b0) rdIdx = 0;
      else if (rdIdx < 16) begin
         phyMdio = rdVal[15 - rdIdx];
         rdIdx++;
      end else phyMdio = 1'b1;
   end
endmodule: mii_phy_model

/* File: mii_pkg.sv */
`include "mii_defines.svh"
package mii_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_FCS} mii_tx_st_t;
   typedef struct packed {
      logic err;
      logic last;
      logic [3:0] nib;
   } mii_txw_t;
   typedef struct packed {
      logic tclkS1, tclkS2, tclkPrev;
      logic crsS1, crsS2, colS1, colS2;
      mii_tx_st_t txSt;
      logic [31:0] crc;
      logic [3:0] cnt;
      logic [4:0] ifg;
      logic bad;
      logic [3:0] txNib;
      logic txEn, txDone, txColl;
      logic rclkS1, rclkS2, rclkPrev;
      logic dvS1, dvS2, erS1, erS2;
      logic [3:0] rnS1, rnS2, rxNib;
      logic rxStb, inFrame, errAcc, rxEnd, rxBad;
      logic [7:0] divCnt;
      logic mdc, mdS1, mdS2, mdBusy, mdRead, mdOut, mdOe, mdDone;
      logic [6:0] mdCnt;
      logic [63:0] mdSh;
      logic [15:0] mdRd;
   } mii_state_t;
endpackage: mii_pkg
